// ---- hct_timing_core.sv ----
`timescale 1ns/1ps
module hct_timing_core
    import hct_pkg::*;
(
    input wire logic clk_in,                  // phase clock, one step per rising edge
    input wire logic rst_in,                  // sync reset, active high
    input wire logic master_clock_in,         // master clock pin
    input wire logic line_sync_n_in,          // line sync pin, active low
    input wire logic field_sync_n_in,         // field sync pin, active low
    input wire logic ser_load_n_in,           // serial frame select, active low
    input wire logic ser_clk_in,              // serial shift clock
    input wire logic ser_data_in,             // serial data, msb first
    output logic reset_gate_clock_out,        // reset gate drive
    output logic horiz_clock_one_out,         // horizontal clock one
    output logic horiz_clock_two_out,         // horizontal clock two
    output logic horiz_clock_three_out,       // horizontal clock three
    output logic horiz_clock_four_out,        // horizontal clock four
    output logic driver_oe_n_out,             // low while drivers are on
    output logic [2:0] driver_current_out,    // driver current steps
    output logic reference_sample_strobe_out, // reference sampling pulse
    output logic data_sample_strobe_out,      // data sampling pulse
    output logic black_level_clamp_n_out,     // clamp pulse, active low
    output logic pixel_blanking_n_out,        // pixel blanking, active low
    output logic horiz_blanking_n_out,        // line blanking, active low
    output logic clock_bias_enable_out,       // master input bias enable
    output logic [CNT_W-1:0] pixel_count_out, // pixel within line
    output logic [CNT_W-1:0] line_count_out   // line within field
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic hct_edge(input logic cur,
                                      input logic [PHASE_W-1:0] ph,
                                      input logic [PHASE_W-1:0] rise,
                                      input logic [PHASE_W-1:0] fall);
        logic nxt;
        nxt = cur;
        if (ph == rise) begin
            nxt = 1'b1;
        end else if (ph == fall) begin
            nxt = 1'b0;
        end
        return nxt;
    endfunction

    function automatic logic hct_in_win(input logic [CNT_W-1:0] pix,
                                        input logic [CNT_W-1:0] t1,
                                        input logic [CNT_W-1:0] t2);
        return (pix >= t1) && (pix < t2);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 6;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    logic [NSYNC-1:0] s3_q;
    logic [NSYNC-1:0] flt_q;
    logic [NSYNC-1:0] flt_d;
    logic [NSYNC-1:0] prev_q;
    logic [NSYNC-1:0] rise_w;
    logic [NSYNC-1:0] fall_w;
    logic [NSYNC-1:0] agree_w;

    assign pin_raw = {ser_data_in, ser_clk_in, ser_load_n_in,
                      field_sync_n_in, line_sync_n_in, master_clock_in};
    assign agree_w = ~(s2_q ^ s3_q);
    assign flt_d = (agree_w & s2_q) | (~agree_w & flt_q);
    assign rise_w = flt_q & ~prev_q;
    assign fall_w = ~flt_q & prev_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s1_q <= {NSYNC{1'b1}};
            s2_q <= {NSYNC{1'b1}};
            s3_q <= {NSYNC{1'b1}};
            flt_q <= {NSYNC{1'b1}};
            prev_q <= {NSYNC{1'b1}};
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            flt_q <= flt_d;
            prev_q <= flt_q;
        end
    end

    wire logic mclk_rise = rise_w[0];
    wire logic line_start = fall_w[1];
    wire logic field_start = fall_w[2];
    wire logic load_n = flt_q[3];
    wire logic load_end = rise_w[3];
    wire logic sck_rise = rise_w[4];
    wire logic sdata = flt_q[5];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic halve_q;
    logic bias_q;
    logic [7:0] mode_reg_q;
    logic [12:0] rg_q;
    logic [12:0] h1_q;
    logic [12:0] h2_q;
    logic [12:0] h3_q;
    logic [11:0] samp_q;
    logic [2:0] drv_q;
    logic [CNT_W-1:0] clp_t1_q;
    logic [CNT_W-1:0] clp_t2_q;
    logic [CNT_W-1:0] pbk_t1_q;
    logic [CNT_W-1:0] pbk_t2_q;
    logic [CNT_W-1:0] hbk_t1_q;
    logic [CNT_W-1:0] hbk_t2_q;

    // ------------------------------------------------------------
    // serial port
    // ------------------------------------------------------------
    hct_ser_t ser_q;
    hct_ser_t ser_d;
    logic [FRAME_W-1:0] shreg_q;
    logic [4:0] nbits_q;

    wire logic [ADDR_W-1:0] wr_addr = shreg_q[FRAME_W-1:DATA_W];
    wire logic [DATA_W-1:0] wr_data = shreg_q[DATA_W-1:0];
    wire logic wr_en = (ser_q == HCT_COMMIT);

    always_comb begin
        ser_d = ser_q;
        case (ser_q)
            HCT_IDLE: begin
                if (!load_n) begin
                    ser_d = HCT_SHIFT;
                end
            end
            HCT_SHIFT: begin
                if (load_end) begin
                    ser_d = (nbits_q == FRAME_BITS) ? HCT_COMMIT : HCT_IDLE;
                end
            end
            HCT_COMMIT: begin
                ser_d = HCT_IDLE;
            end
            default: begin
                ser_d = HCT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ser_q <= HCT_IDLE;
            shreg_q <= '0;
            nbits_q <= 5'h00;
        end else begin
            ser_q <= ser_d;
            if (ser_q == HCT_IDLE) begin
                nbits_q <= 5'h00;
            end else if (ser_q == HCT_SHIFT && sck_rise && !load_n) begin
                shreg_q <= {shreg_q[FRAME_W-2:0], sdata};
                if (nbits_q != 5'h1F) begin
                    nbits_q <= nbits_q + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            halve_q <= 1'b0;
            bias_q <= 1'b0;
            mode_reg_q <= {MODE_ONE, 5'h00};
            rg_q <= RST_RG;
            h1_q <= RST_H1;
            h2_q <= RST_H2;
            h3_q <= RST_H1;
            samp_q <= RST_SAMP;
            drv_q <= RST_DRV;
            clp_t1_q <= RST_TOG;
            clp_t2_q <= RST_TOG;
            pbk_t1_q <= RST_TOG;
            pbk_t2_q <= RST_TOG;
            hbk_t1_q <= RST_TOG;
            hbk_t2_q <= RST_TOG;
        end else if (wr_en) begin
            case (wr_addr)
                ADDR_HALVE: halve_q <= wr_data[0]; // RULE_03
                ADDR_BIAS: bias_q <= wr_data[0]; // RULE_20
                ADDR_MODE: mode_reg_q <= wr_data[7:0]; // RULE_11
                ADDR_RG: rg_q <= wr_data[12:0]; // RULE_04
                ADDR_H1: h1_q <= wr_data[12:0]; // RULE_05
                ADDR_H2: h2_q <= wr_data[12:0]; // RULE_05
                ADDR_H3: h3_q <= wr_data[12:0];
                ADDR_SAMP: samp_q <= wr_data[11:0]; // RULE_14
                ADDR_DRV: drv_q <= wr_data[F_DRV_HI:0]; // RULE_15
                ADDR_CLP_T1: clp_t1_q <= wr_data[CNT_W-1:0]; // RULE_18
                ADDR_CLP_T2: clp_t2_q <= wr_data[CNT_W-1:0];
                ADDR_PBK_T1: pbk_t1_q <= wr_data[CNT_W-1:0];
                ADDR_PBK_T2: pbk_t2_q <= wr_data[CNT_W-1:0];
                ADDR_HBK_T1: hbk_t1_q <= wr_data[CNT_W-1:0];
                ADDR_HBK_T2: hbk_t2_q <= wr_data[CNT_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // phase counter
    // ------------------------------------------------------------
    logic [PHASE_W-1:0] phase_q;
    logic mclk_par_q;

    // with halving only every other master edge marks a pixel
    wire logic mclk_mark = mclk_rise && bias_q && (!halve_q || mclk_par_q); // RULE_03
    wire logic realign = mclk_mark || line_start; // RULE_17
    wire logic pixel_start = realign || (phase_q == PHASE_LAST);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            phase_q <= '0;
            mclk_par_q <= 1'b0;
        end else begin
            if (line_start || !halve_q) begin
                mclk_par_q <= 1'b0;
            end else if (mclk_rise && bias_q) begin
                mclk_par_q <= ~mclk_par_q;
            end
            if (realign) begin
                phase_q <= '0; // RULE_01
            end else begin
                phase_q <= phase_q + 6'h01; // RULE_22
            end
        end
    end

    // ------------------------------------------------------------
    // pixel and line counters
    // ------------------------------------------------------------
    logic [CNT_W-1:0] pix_q;
    logic [CNT_W-1:0] lin_q;
    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pix_q <= '0;
            lin_q <= '0;
        end else begin
            if (line_start) begin
                pix_q <= '0; // RULE_23
            end else if (pixel_start && pix_q != CNT_MAX) begin
                pix_q <= pix_q + 13'h0001; // RULE_16
            end
            if (field_start) begin
                lin_q <= '0; // RULE_23
            end else if (line_start && lin_q != CNT_MAX) begin
                lin_q <= lin_q + 13'h0001; // RULE_16
            end
        end
    end

    // ------------------------------------------------------------
    // edge generation
    // ------------------------------------------------------------
    logic rg_lvl_q;
    logic h1_lvl_q;
    logic h2_lvl_q;
    logic h3_lvl_q;
    wire logic [PHASE_W-1:0] ph = realign ? '0 : phase_q + 6'h01;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rg_lvl_q <= 1'b0;
            h1_lvl_q <= 1'b0;
            h2_lvl_q <= 1'b0;
            h3_lvl_q <= 1'b0;
        end else begin
            // RULE_13
            rg_lvl_q <= hct_edge(rg_lvl_q, ph, rg_q[F_RISE_LO+:PHASE_W],
                                 rg_q[F_FALL_LO+:PHASE_W]); // RULE_04
            h1_lvl_q <= hct_edge(h1_lvl_q, ph, h1_q[F_RISE_LO+:PHASE_W],
                                 h1_q[F_FALL_LO+:PHASE_W]); // RULE_06
            h2_lvl_q <= hct_edge(h2_lvl_q, ph, h2_q[F_RISE_LO+:PHASE_W],
                                 h2_q[F_FALL_LO+:PHASE_W]); // RULE_05
            h3_lvl_q <= hct_edge(h3_lvl_q, ph, h3_q[F_RISE_LO+:PHASE_W],
                                 h3_q[F_FALL_LO+:PHASE_W]);
        end
    end

    // ------------------------------------------------------------
    // pairing, polarity and blanking
    // ------------------------------------------------------------
    wire logic [2:0] mode = mode_reg_q[F_MODE_HI:F_MODE_LO];
    wire logic rg_pol = rg_lvl_q ^ rg_q[F_POL]; // RULE_12
    wire logic h1_pol = h1_lvl_q ^ h1_q[F_POL]; // RULE_12
    wire logic h2_pol = h2_lvl_q ^ h2_q[F_POL];
    wire logic h3_pol = h3_lvl_q ^ h3_q[F_POL];
    wire logic hbk_on = hct_in_win(pix_q, hbk_t1_q, hbk_t2_q); // RULE_18
    logic [3:0] hmap;

    // unused codes fall back to the first pairing
    always_comb begin
        case (mode)
            MODE_TWO: hmap = {h2_pol, h1_pol, h2_pol, h1_pol}; // RULE_08
            MODE_THREE: hmap = {~h3_pol, h3_pol, ~h1_pol, h1_pol}; // RULE_09
            default: hmap = {~h1_pol, h1_pol, ~h1_pol, h1_pol}; // RULE_07
        endcase
    end

    // blanking parks one and three low, two and four high
    wire logic [3:0] hout = hbk_on ? 4'hA : hmap;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reset_gate_clock_out <= 1'b0;
            horiz_clock_one_out <= 1'b0;
            horiz_clock_two_out <= 1'b0;
            horiz_clock_three_out <= 1'b0;
            horiz_clock_four_out <= 1'b0;
            driver_oe_n_out <= 1'b1;
            driver_current_out <= 3'h0;
            reference_sample_strobe_out <= 1'b0;
            data_sample_strobe_out <= 1'b0;
            black_level_clamp_n_out <= 1'b1;
            pixel_blanking_n_out <= 1'b1;
            horiz_blanking_n_out <= 1'b1;
            clock_bias_enable_out <= 1'b0;
            pixel_count_out <= '0;
            line_count_out <= '0;
        end else begin
            reset_gate_clock_out <= rg_pol;
            horiz_clock_one_out <= hout[0];
            horiz_clock_two_out <= hout[1];
            horiz_clock_three_out <= hout[2];
            horiz_clock_four_out <= hout[3];
            driver_oe_n_out <= (drv_q == 3'h0); // RULE_21
            driver_current_out <= drv_q; // RULE_15
            reference_sample_strobe_out <=
                (ph == samp_q[F_RISE_LO+:PHASE_W]); // RULE_14
            data_sample_strobe_out <= (ph == samp_q[F_FALL_LO+:PHASE_W]);
            black_level_clamp_n_out <=
                ~hct_in_win(pix_q, clp_t1_q, clp_t2_q); // RULE_18
            pixel_blanking_n_out <= ~hct_in_win(pix_q, pbk_t1_q, pbk_t2_q);
            horiz_blanking_n_out <= ~hbk_on;
            clock_bias_enable_out <= bias_q; // RULE_20
            pixel_count_out <= pix_q;
            line_count_out <= lin_q;
        end
    end
endmodule

// ---- hct_pkg.sv ----
// Behaviour
// RULE_01: each pixel period splits into 64 edge positions
// RULE_02: master clock runs at pixel rate unless halved
// RULE_03: halve bit at 0x0D allows a twice-rate master clock
// RULE_04: reset gate has own rise and fall positions and polarity
// RULE_05: horizontal clocks one and two each have own edges and polarity
// RULE_06: every edge position setting is six bits wide
// RULE_07: mode 001: one programmable, three copies it, two and four inverted
// RULE_08: mode 010: one and two programmable, three copies one, four copies two
// RULE_09: mode 100: one and three programmable, two and four inverted
// RULE_10: the controller never writes mode 000, 011, 101, 110 or 111
// RULE_11: pairing mode sits in bits 7 to 5 of address 0x23
// RULE_12: polarity bit 0 passes the signal, 1 inverts it
// RULE_13: rise and fall positions select any value 0 to 63
// RULE_14: reference and data strobes each have a six-bit position 0 to 63
// RULE_15: a three-bit drive setting gives 0 to 7 current steps
// RULE_16: pixel and line counters reach 8191
// RULE_17: clocks and counters follow line and field syncs
// RULE_18: clamp and blanking pulses are made inside from settings
// RULE_19: controller keeps edges out of inhibit regions
// RULE_20: bit 0 at clock_input_bias_enable enables master clock input bias
// RULE_21: drive setting 0 turns the drivers off, 7 is the strongest
// RULE_22: a six-bit phase counter runs 0 to 63, edges fire on match
// RULE_23: line sync clears pixel count, field sync clears line count
package hct_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int PHASE_W = 6;
    localparam int CNT_W = 13;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int FRAME_W = ADDR_W + DATA_W;
    localparam logic [PHASE_W-1:0] PHASE_LAST = 6'h3F;
    localparam logic [4:0] FRAME_BITS = 5'h18;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_HALVE = 8'h0D;
    localparam logic [ADDR_W-1:0] ADDR_BIAS = 8'h15;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h23;
    localparam logic [ADDR_W-1:0] ADDR_RG = 8'h30;
    localparam logic [ADDR_W-1:0] ADDR_H1 = 8'h31;
    localparam logic [ADDR_W-1:0] ADDR_H2 = 8'h32;
    localparam logic [ADDR_W-1:0] ADDR_H3 = 8'h33;
    localparam logic [ADDR_W-1:0] ADDR_SAMP = 8'h34;
    localparam logic [ADDR_W-1:0] ADDR_DRV = 8'h35;
    localparam logic [ADDR_W-1:0] ADDR_CLP_T1 = 8'h40;
    localparam logic [ADDR_W-1:0] ADDR_CLP_T2 = 8'h41;
    localparam logic [ADDR_W-1:0] ADDR_PBK_T1 = 8'h42;
    localparam logic [ADDR_W-1:0] ADDR_PBK_T2 = 8'h43;
    localparam logic [ADDR_W-1:0] ADDR_HBK_T1 = 8'h44;
    localparam logic [ADDR_W-1:0] ADDR_HBK_T2 = 8'h45;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int F_RISE_LO = 0;
    localparam int F_FALL_LO = 6;
    localparam int F_POL = 12;
    localparam int F_MODE_HI = 7;
    localparam int F_MODE_LO = 5;
    localparam int F_DRV_HI = 2;

    // ------------------------------------------------------------
    // pairing modes and reset values
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_ONE = 3'h1;
    localparam logic [2:0] MODE_TWO = 3'h2;
    localparam logic [2:0] MODE_THREE = 3'h4;
    localparam logic [12:0] RST_RG = 13'h0400;
    localparam logic [12:0] RST_H1 = 13'h0800;
    localparam logic [12:0] RST_H2 = 13'h0020;
    localparam logic [11:0] RST_SAMP = 12'hE18;
    localparam logic [2:0] RST_DRV = 3'h1;
    localparam logic [CNT_W-1:0] RST_TOG = 13'h0000;

    typedef enum logic [1:0] {
        HCT_IDLE = 2'b00,
        HCT_SHIFT = 2'b01,
        HCT_COMMIT = 2'b11
    } hct_ser_t;
endpackage

// ---- hct_ccd_model.sv ----
`timescale 1ns/1ps
module hct_ccd_model (
    input logic clk_in, // sampling clock
    input logic h1_in, // first horizontal phase
    input logic rg_in, // reset gate
    output int shift_count_out, // packets moved on
    output int gate_count_out // sense node resets
);
    logic h1_q = 1'b0;
    logic rg_q = 1'b0;
    always @(posedge clk_in) begin
        h1_q <= h1_in;
        rg_q <= rg_in;
        shift_count_out <= shift_count_out + int'(h1_in && !h1_q);
        gate_count_out <= gate_count_out + int'(rg_in && !rg_q);
    end
endmodule

// ---- hct_timing_core_chk.sv ----
`timescale 1ns/1ps
module hct_timing_core_chk
    import hct_pkg::*;
(
    input logic clk_in, // clock
    input logic rst_in, // reset
    input logic line_sync_n_in, // line sync
    input logic field_sync_n_in, // field sync
    input logic ser_load_n_in, // frame select
    input logic horiz_clock_one_out, // h one
    input logic horiz_clock_two_out, // h two
    input logic horiz_clock_three_out, // h three
    input logic horiz_clock_four_out, // h four
    input logic driver_oe_n_out, // drivers off
    input logic [2:0] driver_current_out, // drive
    input logic reference_sample_strobe_out, // ref strobe
    input logic data_sample_strobe_out, // data strobe
    input logic clock_bias_enable_out, // bias
    input logic [CNT_W-1:0] pixel_count_out, // pixel
    input logic [CNT_W-1:0] line_count_out // line
);
    // ------------------------------------------------------------
    // cycles since frame close
    // ------------------------------------------------------------
    logic load_prev_q;
    logic [3:0] since_load_q;
    logic [3:0] since_load_d;
    assign since_load_d = (rst_in || (ser_load_n_in && !load_prev_q)) ? 4'h0
        : (since_load_q == 4'hF) ? 4'hF : since_load_q + 4'h1;
    always_ff @(posedge clk_in) begin
        load_prev_q <= ser_load_n_in;
        since_load_q <= since_load_d;
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking dc @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    a_pair_odd: assert property (
        horiz_clock_three_out == horiz_clock_one_out ||
        (horiz_clock_two_out != horiz_clock_one_out &&
        horiz_clock_four_out != horiz_clock_three_out))
        else $error("odd horizontal pairing broken");
    a_pair_even: assert property (
        horiz_clock_four_out == horiz_clock_two_out ||
        horiz_clock_two_out != horiz_clock_one_out)
        else $error("even horizontal pairing broken");
    a_drive_off: assert property (
        driver_oe_n_out == (driver_current_out == 3'h0))
        else $error("driver enable disagrees with drive");
    a_ref_pulse: assert property (
        reference_sample_strobe_out |=> !reference_sample_strobe_out)
        else $error("reference strobe wider than one clock");
    a_data_pulse: assert property (
        $rose(data_sample_strobe_out) |=> $fell(data_sample_strobe_out))
        else $error("data strobe wider than one clock");
    a_pixel_step: assert property (
        $changed(pixel_count_out) |->
        pixel_count_out == $past(pixel_count_out) + 13'h0001 ||
        pixel_count_out == 13'h0000)
        else $error("pixel count jumped");
    a_line_step: assert property (
        $changed(line_count_out) |->
        line_count_out == $past(line_count_out) + 13'h0001 ||
        line_count_out == 13'h0000)
        else $error("line count jumped");
    a_line_clear: assert property (
        $fell(line_sync_n_in) |-> ##[3:10] pixel_count_out <= 13'h0001)
        else $error("line start did not clear pixel count");
    a_field_clear: assert property (
        $fell(field_sync_n_in) |-> ##[3:10] line_count_out <= 13'h0001)
        else $error("field start did not clear line count");
    a_write_window: assert property (
        $changed(clock_bias_enable_out) || $changed(driver_current_out)
        |-> since_load_q inside {[4'h1:4'hC]})
        else $error("setting changed outside a write");
    c_ref: cover property (reference_sample_strobe_out);
    c_clear: cover property ($fell(line_sync_n_in) ##4 !line_sync_n_in);
    c_bias: cover property ($rose(clock_bias_enable_out));
endmodule

bind hct_timing_core hct_timing_core_chk u_chk (.*);

// ---- hct_timing_core_bench.sv ----
`timescale 1ns/1ps
module hct_timing_core_bench
    import hct_pkg::*;
();
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ls_n = 1'b1;
    logic fs_n = 1'b1;
    logic load_n = 1'b1;
    logic sclk = 1'b0;
    logic sdata = 1'b0;
    logic mclk = 1'b0;
    logic rg, h1, h2, h3, h4, oe_n, refs, dats, clp_n, pbk_n, hbk_n, bias;
    logic [2:0] cur;
    logic [CNT_W-1:0] pix, lin;
    logic [9:0] obs;
    int miscompares, compares, shifts, gates, n, m;
    int mhalf = 32;
    int mcnt = 0;
    logic [5:0] er [3] = '{6'h05, 6'h3F, 6'h0A};
    logic [5:0] ef [3] = '{6'h06, 6'h00, 6'h3C};
    logic [2:0] md [3] = '{MODE_ONE, MODE_TWO, MODE_THREE};
    int ex [3][3] = '{'{32, 32, 32}, '{12, 32, 12}, '{32, 10, 54}};
    assign obs = {~hbk_n, ~pbk_n, ~clp_n, dats, refs, rg, h4, h3, h2, h1};

    hct_timing_core dut (.clk_in(clk_in), .rst_in(rst_in),
        .master_clock_in(mclk), .line_sync_n_in(ls_n),
        .field_sync_n_in(fs_n), .ser_load_n_in(load_n), .ser_clk_in(sclk),
        .ser_data_in(sdata), .reset_gate_clock_out(rg),
        .horiz_clock_one_out(h1), .horiz_clock_two_out(h2),
        .horiz_clock_three_out(h3), .horiz_clock_four_out(h4),
        .driver_oe_n_out(oe_n), .driver_current_out(cur),
        .reference_sample_strobe_out(refs), .data_sample_strobe_out(dats),
        .black_level_clamp_n_out(clp_n), .pixel_blanking_n_out(pbk_n),
        .horiz_blanking_n_out(hbk_n), .clock_bias_enable_out(bias),
        .pixel_count_out(pix), .line_count_out(lin));
    hct_ccd_model ccd (.clk_in(clk_in), .h1_in(h1), .rg_in(rg),
        .shift_count_out(shifts), .gate_count_out(gates));

    // ------------------------------------------------------------
    // clocks, watchdog, tasks
    // ------------------------------------------------------------
    initial begin
        forever #20 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        mcnt <= (mcnt + 1) % (2 * mhalf);
        mclk <= #2 (mcnt < mhalf);
    end
    initial begin
        #(40 * 30000);
        miscompares++;
        $display("MISMATCH watchdog expected done seen hang");
        summarize();
    end
    task automatic tick(input int k);
        repeat (k) @(posedge clk_in);
        #2;
    endtask
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic ser_frame(input logic [7:0] a, input logic [15:0] d,
                             input int nbits);
        logic [23:0] f;
        f = {a, d};
        load_n = 1'b0;
        for (int i = 23; i >= 24 - nbits; i--) begin
            tick(4);
            sdata = f[i];
            tick(4);
            sclk = 1'b1;
            tick(4);
            sclk = 1'b0;
        end
        tick(4);
        load_n = 1'b1;
        tick(12);
    endtask
    // cycles from obs[a] rising to obs[b] reaching lvl
    task automatic gap(input int a, input int b, input logic lvl,
                       output int cnt);
        logic p;
        int t;
        t = 0;
        do begin
            p = obs[a];
            @(negedge clk_in);
            t++;
        end while (!(p === 1'b0 && obs[a] === 1'b1) && t < 300);
        cnt = 0;
        do begin
            p = obs[b];
            @(negedge clk_in);
            cnt++;
        end while (!(p === ~lvl && obs[b] === lvl) && cnt < 300);
        tick(1);
    endtask
    task automatic pulse(input bit fld);
        if (fld) begin
            fs_n = 1'b0;
        end else begin
            ls_n = 1'b0;
        end
        tick(8);
        fs_n = 1'b1;
        ls_n = 1'b1;
        tick(192);
    endtask
    task automatic summarize();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        tick(8);
        rst_in = 1'b0;
        tick(4);
        check("drive", 16'(RST_DRV), 16'(cur));
        check("driver off", 16'h0000, 16'(oe_n));
        check("bias", 16'h0000, 16'(bias));
        gap(0, 0, 1, n);
        check("h1 period", 16'h0040, 16'(n));
        gap(0, 0, 0, n);
        check("h1 high", 16'h0020, 16'(n));
        gap(4, 4, 0, n);
        check("rg high", 16'h0010, 16'(n));
        gap(5, 6, 1, n);
        check("strobe gap", 16'h0020, 16'(n));
        m = shifts;
        n = gates;
        tick(640);
        check("shifts", 16'h000A, 16'(shifts - m));
        check("gate pulses", 16'h000A, 16'(gates - n));
        for (int i = 0; i < 3; i++) begin
            ser_frame(ADDR_H1, {4'h0, ef[i], er[i]}, 24);
            gap(0, 0, 0, n);
            check("h1 high", 16'(6'(ef[i] - er[i])), 16'(n));
        end
        ser_frame(ADDR_H1, 16'(RST_H1), 24);
        ser_frame(ADDR_RG, 16'h1400, 24);
        gap(4, 4, 0, n);
        check("rg inverted high", 16'h0030, 16'(n));
        ser_frame(ADDR_H2, 16'h0508, 24);
        ser_frame(ADDR_H3, 16'h0794, 24);
        for (int k = 0; k < 3; k++) begin
            ser_frame(ADDR_MODE, {8'h00, md[k], 5'h00}, 24);
            for (int j = 1; j < 4; j++) begin
                gap(j, j, 0, n);
                check("pair", 16'(ex[k][j-1]), 16'(n));
            end
        end
        ser_frame(ADDR_SAMP, 16'h007E, 24);
        gap(5, 6, 1, n);
        check("strobe wrap gap", 16'h0003, 16'(n));
        for (int i = 0; i < 2; i++) begin
            ser_frame(ADDR_DRV, 16'(7 * i), 24);
            check("drive", 16'(7 * i), 16'(cur));
            check("driver off", 16'(1 - i), 16'(oe_n));
        end
        ser_frame(ADDR_DRV, 16'h0003, 23);
        check("short frame", 16'h0007, 16'(cur));
        ser_frame(ADDR_BIAS, 16'h0001, 24);
        check("bias", 16'h0001, 16'(bias));
        mhalf = 16;
        ser_frame(ADDR_HALVE, 16'h0001, 24);
        gap(0, 0, 1, n);
        gap(0, 0, 1, n);
        check("halved period", 16'h0040, 16'(n));
        ser_frame(ADDR_BIAS, 16'h0000, 24);
        pulse(1'b1);
        repeat (3) pulse(1'b0);
        check("line count", 16'h0003, 16'(lin));
        check("pixel count", 16'h0001,
              16'(pix === 13'h0003 || pix === 13'h0004));
        for (int k = 0; k < 3; k++) begin
            ser_frame(ADDR_CLP_T1 + 8'(2 * k), 16'h0004, 24);
            ser_frame(ADDR_CLP_T2 + 8'(2 * k), 16'h0007, 24);
        end
        for (int k = 7; k < 10; k++) begin
            pulse(1'b0);
            gap(k, k, 0, n);
            check("window width", 16'h00C0, 16'(n));
        end
        summarize();
    end
endmodule
